// [src/np_regs_pkg.sv]
// Constants for the autonegotiation next page register bank
package np_regs_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int          ADR_W        = 23;
    localparam int          DEV_LSB      = 18;
    localparam int          IDX_LSB      = 2;
    localparam logic [4:0]  DEV_SPACE    = 5'h07;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [15:0] IDX_TX_LOW   = 16'h0208;
    localparam logic [15:0] IDX_TX_MID   = 16'h0209;
    localparam logic [15:0] IDX_TX_HIGH  = 16'h020A;
    localparam logic [15:0] IDX_LP_LOW   = 16'h020B;
    localparam logic [15:0] IDX_LP_MID   = 16'h020C;
    localparam logic [15:0] IDX_LP_HIGH  = 16'h020D;
    localparam logic [15:0] IDX_NP_STAT  = 16'h8100;

    // ------------------------------------------------------------------
    // Reset values and write masks
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_TX_LOW   = 16'h2001;
    localparam logic [15:0] RST_TX_MID   = 16'h0000;
    localparam logic [15:0] RST_TX_HIGH  = 16'h0000;
    localparam logic [15:0] WMASK_TX_LOW = 16'hB7FF;
    localparam logic [15:0] WMASK_FULL   = 16'hFFFF;

    // ------------------------------------------------------------------
    // Low word field positions
    // ------------------------------------------------------------------
    localparam int          BIT_MORE_PAGES = 15;
    localparam int          BIT_PAGE_ACK   = 14;
    localparam int          BIT_ENCODING   = 13;
    localparam int          BIT_COMPLY_ACK = 12;
    localparam int          BIT_SYNC_TOG   = 11;
    localparam int          CODE_MSB       = 10;

    // ------------------------------------------------------------------
    // Message codes
    // ------------------------------------------------------------------
    localparam logic [10:0] MSG_NULL       = 11'h001;
    localparam logic [10:0] MSG_OUI_TAGGED = 11'h005;
    localparam logic [10:0] MSG_DEVICE_ID  = 11'h006;

    // ------------------------------------------------------------------
    // Status register bits
    // ------------------------------------------------------------------
    localparam int          STAT_READY     = 0;
    localparam int          STAT_ACK       = 1;

endpackage : np_regs_pkg

// [src/field_reg.sv]
// Sixteen-bit software register with reset value, reload and write mask
module field_reg #(
    parameter logic [15:0] RESET = 16'h0000,
    parameter logic [15:0] WMASK = 16'hFFFF
) (
    input  wire logic        clk_i,     // System clock
    input  wire logic        rst_i,     // Async reset, high
    input  wire logic        reload_i,  // Return to reset value
    input  wire logic        we_i,      // Write strobe
    input  wire logic [1:0]  sel_i,     // Byte lanes
    input  wire logic [15:0] d_i,       // Write data
    output logic      [15:0] q_o        // Stored value
);
    wire [15:0] lane_mask = WMASK & {{8{sel_i[1]}}, {8{sel_i[0]}}};

    // Non-writable bits keep their reset value forever
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_o <= RESET;
        end else if (reload_i) begin
            q_o <= RESET;
        end else if (we_i) begin
            q_o <= (q_o & ~lane_mask) | (d_i & lane_mask);
        end
    end
endmodule : field_reg

// [src/hold_reg.sv]
// Loadable holding register cleared by reset
module hold_reg #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk_i,   // System clock
    input  wire logic             rst_i,   // Async reset, high
    input  wire logic             load_i,  // Capture strobe
    input  wire logic [WIDTH-1:0] d_i,     // Value to capture
    output logic      [WIDTH-1:0] q_o      // Held value
);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_o <= '0;
        end else if (load_i) begin
            q_o <= d_i;
        end
    end
endmodule : hold_reg

// [src/autoneg_next_page_regs.sv]
// Autonegotiation next page register bank behind a classic Wishbone slave
//
// Notes on behaviour
// - The transmit words sit in device space 7, the low transmit word at register 0x0208.
// - Power-up and autonegotiation reset load the low transmit word with 0x2001, a null message page.
// - Low word bit 15 is a writable more-pages request, reset to zero.
// - Low word bit 14 is a read-only acknowledge indication, reset to zero, unaffected by writes.
// - Low word bit 13 is a writable encoding select, reset to one, one meaning a message page.
// - Low word bit 12 is a writable comply acknowledge, reset to zero.
// - Low word bit 11 always reads zero; the link toggle is made by the arbitration logic.
// - Low word bits 10 to 0 are a writable code field resetting to 1 (1 null, 5 OUI tagged, 6 device id).
// - The middle transmit word at 0x0209 is a writable field, reset zero, for page bits 31 to 16.
// - The high transmit word at 0x020A is a writable field, reset zero, for page bits 47 to 32.
// - Reading the partner low word at 0x020B captures the partner middle and high words.
// - The partner low word reads back request, acknowledge, encoding, comply, toggle and code, reset zero.
// - Partner middle (0x020C) and high (0x020D) words return the values held at the last low-word read.
//
// Register map, device space 7, byte address four times the index:
//   0x0208 next_page_tx_low        page bits 15:0, written last
//   0x0209 next_page_tx_mid        page bits 31:16
//   0x020A next_page_tx_high       page bits 47:32
//   0x020B partner_next_page_low   partner bits 15:0, live
//   0x020C partner_next_page_mid   partner bits 31:16, snapshot
//   0x020D partner_next_page_high  partner bits 47:32, snapshot
//   0x8100 status                  bit 0 page ready, bit 1 acknowledge state
// Other indices answer with zero data and ignore writes.
// A low-word write arms the page; page_taken_i disarms it, except that a
// low-word write landing on the same edge keeps it armed.
//
// The Wishbone register port was chosen for this implementation.
module autoneg_next_page_regs
    import np_regs_pkg::*;
(
    input  wire logic             clk_i,            // System clock, 10 MHz
    input  wire logic             rst_i,            // Async reset, high
    // Wishbone classic slave
    input  wire logic [ADR_W-1:0] adr_i,            // Byte address
    input  wire logic [31:0]      dat_i,            // Write data
    output logic      [31:0]      dat_o,            // Read data
    input  wire logic             we_i,             // Write enable
    input  wire logic [3:0]       sel_i,            // Byte selects
    input  wire logic             cyc_i,            // Cycle
    input  wire logic             stb_i,            // Strobe
    output logic                  ack_o,            // Acknowledge
    // Arbitration side
    input  wire logic             an_reset_i,       // Autonegotiation reset
    input  wire logic             page_ack_i,       // Local acknowledge state
    input  wire logic [47:0]      partner_page_i,   // Live received partner page
    input  wire logic             page_taken_i,     // Ready page consumed
    output logic      [47:0]      tx_page_o,        // Page to transmit
    output logic                  tx_page_ready_o,  // Page waiting to be sent
    output logic                  tx_page_load_o    // Low word just written
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire        req        = cyc_i & stb_i & ~ack_o;
    wire        dev_hit    = (adr_i[ADR_W-1:DEV_LSB] == DEV_SPACE);
    wire [15:0] reg_idx    = adr_i[DEV_LSB-1:IDX_LSB];
    wire        hit_tx_low = dev_hit & (reg_idx == IDX_TX_LOW);
    wire        hit_tx_mid = dev_hit & (reg_idx == IDX_TX_MID);
    wire        hit_tx_hi  = dev_hit & (reg_idx == IDX_TX_HIGH);
    wire        hit_lp_low = dev_hit & (reg_idx == IDX_LP_LOW);
    wire        hit_lp_mid = dev_hit & (reg_idx == IDX_LP_MID);
    wire        hit_lp_hi  = dev_hit & (reg_idx == IDX_LP_HIGH);
    wire        hit_stat   = dev_hit & (reg_idx == IDX_NP_STAT);
    wire        wr_req     = req & we_i;
    wire        rd_req     = req & ~we_i;
    wire        wr_tx_low  = wr_req & hit_tx_low;

    // Strobes for the words that act on an accepted request
    wire        wr_tx_mid  = wr_req & hit_tx_mid;
    wire        wr_tx_hi   = wr_req & hit_tx_hi;
    wire        rd_lp_low  = rd_req & hit_lp_low;

    // ------------------------------------------------------------------
    // Transmit page words
    // ------------------------------------------------------------------
    wire [15:0] tx_low;
    wire [15:0] tx_mid;
    wire [15:0] tx_high;

    // Acknowledge and toggle bits are masked off: stored zero forever
    field_reg #(
        .RESET (RST_TX_LOW),
        .WMASK (WMASK_TX_LOW)
    ) u_tx_low (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .reload_i (an_reset_i),
        .we_i     (wr_tx_low),
        .sel_i    (sel_i[1:0]),
        .d_i      (dat_i[15:0]),
        .q_o      (tx_low)
    );

    field_reg #(
        .RESET (RST_TX_MID),
        .WMASK (WMASK_FULL)
    ) u_tx_mid (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .reload_i (an_reset_i),
        .we_i     (wr_tx_mid),
        .sel_i    (sel_i[1:0]),
        .d_i      (dat_i[15:0]),
        .q_o      (tx_mid)
    );

    field_reg #(
        .RESET (RST_TX_HIGH),
        .WMASK (WMASK_FULL)
    ) u_tx_high (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .reload_i (an_reset_i),
        .we_i     (wr_tx_hi),
        .sel_i    (sel_i[1:0]),
        .d_i      (dat_i[15:0]),
        .q_o      (tx_high)
    );

    // Page as software composed it; the link inserts its own toggle
    assign tx_page_o = {tx_high, tx_mid, tx_low};

    // ------------------------------------------------------------------
    // Local acknowledge indication
    // ------------------------------------------------------------------
    logic page_ack;

    // An autonegotiation reset drops the indication with the page words
    wire  next_page_ack = page_ack_i & ~an_reset_i;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            page_ack <= 1'b0;
        end else begin
            page_ack <= next_page_ack;
        end
    end

    // ------------------------------------------------------------------
    // Transmit low word as software reads it back
    // ------------------------------------------------------------------
    wire        more_pages_request   = tx_low[BIT_MORE_PAGES];
    wire        page_acknowledge     = page_ack;
    wire        page_encoding_select = tx_low[BIT_ENCODING];
    wire        comply_acknowledge   = tx_low[BIT_COMPLY_ACK];
    wire        page_sync_toggle     = tx_low[BIT_SYNC_TOG];
    wire [10:0] page_code_field      = tx_low[CODE_MSB:0];

    wire [15:0] tx_low_view = {
        more_pages_request,
        page_acknowledge,
        page_encoding_select,
        comply_acknowledge,
        page_sync_toggle,
        page_code_field
    };

    // ------------------------------------------------------------------
    // Partner page: one registered copy keeps all three words coherent
    // ------------------------------------------------------------------
    wire [15:0] partner_low;
    wire [15:0] partner_mid;
    wire [15:0] partner_high;
    wire [15:0] held_mid;
    wire [15:0] held_high;

    // One registered copy per word, all sampled on the same edge
    hold_reg #(
        .WIDTH (16)
    ) u_partner_low (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .load_i (1'b1),
        .d_i    (partner_page_i[15:0]),
        .q_o    (partner_low)
    );

    hold_reg #(
        .WIDTH (16)
    ) u_partner_mid (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .load_i (1'b1),
        .d_i    (partner_page_i[31:16]),
        .q_o    (partner_mid)
    );

    hold_reg #(
        .WIDTH (16)
    ) u_partner_high (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .load_i (1'b1),
        .d_i    (partner_page_i[47:32]),
        .q_o    (partner_high)
    );

    // Snapshot taken on the same edge the low word is answered
    hold_reg #(
        .WIDTH (16)
    ) u_held_mid (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .load_i (rd_lp_low),
        .d_i    (partner_mid),
        .q_o    (held_mid)
    );

    hold_reg #(
        .WIDTH (16)
    ) u_held_high (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .load_i (rd_lp_low),
        .d_i    (partner_high),
        .q_o    (held_high)
    );

    // ------------------------------------------------------------------
    // Partner low word fields, live from the registered copy
    // ------------------------------------------------------------------
    wire        partner_more_pages_request = partner_low[BIT_MORE_PAGES];
    wire        partner_page_acknowledge   = partner_low[BIT_PAGE_ACK];
    wire        partner_page_encoding      = partner_low[BIT_ENCODING];
    wire        partner_comply_acknowledge = partner_low[BIT_COMPLY_ACK];
    wire        partner_sync_toggle        = partner_low[BIT_SYNC_TOG];
    wire [10:0] partner_code_field         = partner_low[CODE_MSB:0];

    wire [15:0] partner_low_view = {
        partner_more_pages_request,
        partner_page_acknowledge,
        partner_page_encoding,
        partner_comply_acknowledge,
        partner_sync_toggle,
        partner_code_field
    };

    // ------------------------------------------------------------------
    // Page ready handshake
    // ------------------------------------------------------------------
    // Only the low word arms the page, so mid and high must already hold
    wire set_ready   = wr_tx_low;
    wire clear_ready = page_taken_i;
    // Set wins over the take; the autonegotiation reset wins over both
    wire next_ready  = an_reset_i  ? 1'b0 :
                       set_ready   ? 1'b1 :
                       clear_ready ? 1'b0 : tx_page_ready_o;
    wire next_load   = wr_tx_low & ~an_reset_i;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_page_ready_o <= 1'b0;
        end else begin
            tx_page_ready_o <= next_ready;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_page_load_o <= 1'b0;
        end else begin
            tx_page_load_o <= next_load;
        end
    end

    // ------------------------------------------------------------------
    // Read data and acknowledge
    // ------------------------------------------------------------------
    // Status word: ready flag and acknowledge state, read only
    wire [15:0] stat_view = (16'(tx_page_ready_o) << STAT_READY) |
                            (16'(page_ack) << STAT_ACK);

    // Unmapped addresses still answer, with zero data
    wire [15:0] next_rdata =
        hit_tx_low ? tx_low_view :
        hit_tx_mid ? tx_mid :
        hit_tx_hi  ? tx_high :
        hit_lp_low ? partner_low_view :
        hit_lp_mid ? held_mid :
        hit_lp_hi  ? held_high :
        hit_stat   ? stat_view : 16'h0000;

    // Every request is answered after one cycle, then ack idles a cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // Read data holds until the next accepted read
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else if (rd_req) begin
            dat_o <= {16'h0000, next_rdata};
        end
    end

endmodule : autoneg_next_page_regs

// [verification/np_regs_sva.sv]
// Assertion checker for the next page register bank
module np_regs_sva
    import np_regs_pkg::*;
(
    input wire logic             clk_i,           // Clock
    input wire logic             rst_i,           // Reset
    input wire logic [ADR_W-1:0] adr_i,           // Address
    input wire logic [31:0]      dat_i,           // Write data
    input wire logic [31:0]      dat_o,           // Read data
    input wire logic             we_i,            // Write
    input wire logic [3:0]       sel_i,           // Lanes
    input wire logic             cyc_i,           // Cycle
    input wire logic             stb_i,           // Strobe
    input wire logic             ack_o,           // Ack
    input wire logic             an_reset_i,      // AN reset
    input wire logic             page_ack_i,      // Ack state
    input wire logic [47:0]      partner_page_i,  // Partner page
    input wire logic             page_taken_i,    // Page taken
    input wire logic [47:0]      tx_page_o,       // Tx page
    input wire logic             tx_page_ready_o, // Ready
    input wire logic             tx_page_load_o   // Load pulse
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic        take = cyc_i && stb_i && !ack_o;
    wire logic        mine = take && adr_i[22:18] == DEV_SPACE;
    wire logic [15:0] idx  = adr_i[17:2];
    wire logic        wr   = mine && we_i && !an_reset_i;
    wire logic        rd   = mine && !we_i;
    sequence s_take; take; endsequence
    sequence s_pulse; ack_o ##1 !ack_o; endsequence
    property p_ack; s_take |=> s_pulse; endproperty
    property p_wlow; wr && idx == IDX_TX_LOW |=> tx_page_load_o && tx_page_ready_o; endproperty
    property p_taken; tx_page_ready_o && page_taken_i && !take && !an_reset_i |=> !tx_page_ready_o; endproperty
    property p_anrst; an_reset_i |=> tx_page_o == {32'h0, RST_TX_LOW} && !tx_page_ready_o; endproperty
    property p_wmid; wr && idx == IDX_TX_MID && sel_i[1:0] == 2'b11 |=> tx_page_o[31:16] == $past(dat_i[15:0]); endproperty
    property p_whigh; wr && idx == IDX_TX_HIGH && sel_i[1:0] == 2'b11 |=> tx_page_o[47:32] == $past(dat_i[15:0]); endproperty
    property p_rlow; rd && idx == IDX_TX_LOW |=> !dat_o[11] && dat_o[31:16] == 16'h0000; endproperty
    property p_rack; rd && idx == IDX_TX_LOW && !$past(an_reset_i) |=> dat_o[14] == $past(page_ack_i, 2); endproperty
    property p_rlp; rd && idx == IDX_LP_LOW |=> dat_o[15:0] == $past(partner_page_i[15:0], 2); endproperty
    property p_bad; take && !we_i && adr_i[22:18] != DEV_SPACE |=> dat_o == 32'h0; endproperty
    a_ack: assert property (p_ack) else $error("ack not a single pulse");
    a_wlow: assert property (p_wlow) else $error("low write not loaded");
    a_taken: assert property (p_taken) else $error("ready kept after take");
    a_anrst: assert property (p_anrst) else $error("an reset value wrong");
    a_wmid: assert property (p_wmid) else $error("mid word wrong");
    a_whigh: assert property (p_whigh) else $error("high word wrong");
    a_rlow: assert property (p_rlow) else $error("toggle bit not zero");
    a_rack: assert property (p_rack) else $error("ack bit wrong");
    a_rlp: assert property (p_rlp) else $error("partner low wrong");
    a_bad: assert property (p_bad) else $error("foreign space read");
endmodule : np_regs_sva

bind autoneg_next_page_regs np_regs_sva u_np_regs_sva (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i,
    .cyc_i, .stb_i, .ack_o, .an_reset_i, .page_ack_i, .partner_page_i, .page_taken_i, .tx_page_o, .tx_page_ready_o,
    .tx_page_load_o);

// [verification/np_partner_model.sv]
// Behavioural link partner on the arbitration side
module np_partner_model (
    input  wire logic        clk_i,          // Clock
    input  wire logic        rst_i,          // Reset
    input  wire logic        ready_i,        // Local page waiting
    input  wire logic        slow_i,         // Take pages late
    input  wire logic        ack_req_i,      // Acknowledge state wanted
    input  wire logic [47:0] page_i,         // Page to present
    output logic      [47:0] partner_page_o, // Received page
    output logic             taken_o,        // Page consumed
    output logic             ack_o           // Acknowledge state
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] wait_cnt;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_cnt       <= 3'h0;
            taken_o        <= 1'b0;
            ack_o          <= 1'b0;
            partner_page_o <= 48'h0;
        end else begin
            partner_page_o <= page_i;
            ack_o          <= ack_req_i;
            taken_o        <= 1'b0;
            wait_cnt       <= (ready_i && !taken_o) ? wait_cnt + 3'h1 : 3'h0;
            if (ready_i && !taken_o && wait_cnt == (slow_i ? 3'h5 : 3'h1)) begin
                taken_o  <= 1'b1;
                wait_cnt <= 3'h0;
            end
        end
    end
endmodule : np_partner_model

// [verification/autoneg_next_page_regs_test.sv]
// Self-checking bench for the next page register bank
module autoneg_next_page_regs_test
    import np_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic             clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0;
    logic             an_reset_i = 0, slow = 0, ack_req = 0;
    logic [ADR_W-1:0] adr_i = '0;
    logic [31:0]      dat_i = '0;
    logic [3:0]       sel_i = '0;
    logic [47:0]      lp_val = '0, rd;
    logic [10:0]      codes [3] = '{MSG_NULL, MSG_OUI_TAGGED, MSG_DEVICE_ID};
    wire logic [31:0] dat_o;
    wire logic [47:0] lp_page, tx_page;
    wire logic        ack_o, page_ack, taken, ready;
    int               num_errors = 0, checked = 0;

    autoneg_next_page_regs u_autoneg_next_page_regs (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i,
        .cyc_i, .stb_i, .ack_o, .an_reset_i, .page_ack_i(page_ack), .partner_page_i(lp_page),
        .page_taken_i(taken), .tx_page_o(tx_page), .tx_page_ready_o(ready), .tx_page_load_o());
    np_partner_model u_np_partner_model (.clk_i, .rst_i, .ready_i(ready), .slow_i(slow), .ack_req_i(ack_req),
        .page_i(lp_val), .partner_page_o(lp_page), .taken_o(taken), .ack_o(page_ack));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    task automatic conclude;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk

    // Request held from the edge after the call until the edge that sees ack
    task automatic wb(input logic w, input logic [15:0] idx, input logic [15:0] d,
                      input logic [1:0] s = 2'b11, input logic [4:0] dev = DEV_SPACE);
        int n;
        n = 0;
        {cyc_i, stb_i, we_i} <= {2'b11, w};
        adr_i <= {dev, idx, 2'b00};
        dat_i <= {16'h0, d};
        sel_i <= {2'b00, s};
        do begin @(posedge clk_i); #1; n++; end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            num_errors++;
            $display("BAD %0t no ack", $time);
            conclude();
        end
        rd = {16'h0, dat_o};
        @(posedge clk_i);
        {cyc_i, stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask : wb

    task automatic t_reset;
        chk(tx_page, 48'h2001);
        wb(0, IDX_TX_LOW, 0); chk(rd, 48'h2001);
        wb(0, IDX_TX_MID, 0); chk(rd, 48'h0);
        wb(0, IDX_TX_HIGH, 0); chk(rd, 48'h0);
        wb(0, IDX_LP_LOW, 0); chk(rd, 48'h0);
        $display("reset values done");
    endtask : t_reset

    task automatic t_page;
        int n;
        slow <= 1;
        ack_req <= 1;
        wb(1, IDX_TX_MID, 16'h1234);
        wb(1, IDX_TX_HIGH, 16'hABCD);
        wb(1, IDX_TX_LOW, 16'hFFFF);
        chk(tx_page, 48'hABCD_1234_B7FF);
        chk({47'h0, ready}, 48'h1);
        wb(0, IDX_NP_STAT, 0); chk(rd, 48'h3);
        wb(0, IDX_TX_LOW, 0); chk(rd, 48'hF7FF);
        ack_req <= 0;
        n = 0;
        while (ready !== 1'b0 && n < 20) begin @(posedge clk_i); n++; end
        chk({47'h0, ready}, 48'h0);
        slow <= 0;
        foreach (codes[i]) begin
            wb(1, IDX_TX_LOW, {5'b00100, codes[i]});
            wb(0, IDX_TX_LOW, 0); chk(rd, {37'h0, 5'b00100, codes[i]});
        end
        wb(1, IDX_TX_LOW, 16'h0000, 2'b10);
        wb(0, IDX_TX_LOW, 0); chk(rd, 48'h0006);
        $display("page compose done");
    endtask : t_page

    task automatic t_partner;
        lp_val <= 48'h1111_2222_A5C3;
        wb(0, IDX_LP_MID, 0); chk(rd, 48'h0);
        wb(0, IDX_LP_LOW, 0); chk(rd, 48'hA5C3);
        lp_val <= 48'h3333_4444_0000;
        wb(0, IDX_LP_MID, 0); chk(rd, 48'h2222);
        wb(0, IDX_LP_HIGH, 0); chk(rd, 48'h1111);
        wb(0, IDX_LP_LOW, 0); chk(rd, 48'h0);
        wb(0, IDX_LP_HIGH, 0); chk(rd, 48'h3333);
        $display("partner snapshot done");
    endtask : t_partner

    task automatic t_anrst;
        slow <= 1;
        wb(1, IDX_TX_MID, 16'h5555);
        wb(1, IDX_TX_LOW, 16'h8001);
        an_reset_i <= 1;
        @(posedge clk_i);
        an_reset_i <= 0;
        wb(0, IDX_TX_LOW, 0); chk(rd, 48'h2001);
        chk(tx_page, 48'h2001);
        chk({47'h0, ready}, 48'h0);
        $display("an reset done");
    endtask : t_anrst

    task automatic t_unmapped;
        wb(1, IDX_TX_MID, 16'hFFFF, 2'b11, 5'h06);
        wb(0, IDX_TX_MID, 0, 2'b11, 5'h06); chk(rd, 48'h0);
        wb(0, IDX_TX_MID, 0); chk(rd, 48'h0);
        wb(0, 16'h0300, 0); chk(rd, 48'h0);
        $display("address map done");
    endtask : t_unmapped

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        t_reset();
        t_page();
        t_partner();
        t_anrst();
        t_unmapped();
        conclude();
    end
endmodule : autoneg_next_page_regs_test
